// *** core/xpoint_pkg.sv ***
// constants, types and decode functions for the crosspoint control registers
// Overview of operation
// - answer at byte address 0x06 with strap low, 0x86 with strap high.
// - each access is a register address byte then a data byte.
// - one register per output at 0x01 to 0x09.
// - bit 7 enables the output, zero powers it down; default zero.
// - bits 6:5 pick gain 6, 7, 8 or 9 dB; default 00.
// - bits 4:0 pick the source input, zero means none; default zero.
// - any number of outputs may select the same input at once.
// - a disabled output drives its high-impedance control active.
// - a powered-down output routes no input whatever code is stored.
// - clamp bits at 0x1D for inputs 1-8, 0x1E bits 3:0 for 9-12.
// - a clamp bit of one selects clamp, zero selects bias; default zero.
// - writes to other register addresses are acknowledged but change nothing.
// - write-only standard-mode slave; no read-back is offered.
package xpoint_pkg;
  localparam int          NUM_OUT       = 9;
  localparam int          NUM_IN        = 12;
  localparam int          BYTE_W        = 8;
  localparam int          CNT_W         = 4;
  localparam int          GAIN_W        = 2;
  localparam int          SEL_W         = 5;
  localparam int          CLAMP_HI_W    = 4;
  localparam int          SYNC_W        = 3;
  localparam int          EN_BIT        = 7;
  localparam int          GAIN_MSB      = 6;
  localparam int          GAIN_LSB      = 5;
  localparam int          SEL_MSB       = 4;
  localparam int          SEL_LSB       = 0;
  localparam logic [7:0]  ADDR_PRIMARY  = 8'h06;
  localparam logic [7:0]  ADDR_ALT      = 8'h86;
  localparam logic [7:0]  REG_OUT_FIRST = 8'h01;
  localparam logic [7:0]  REG_OUT_LAST  = 8'h09;
  localparam logic [7:0]  REG_CLAMP_LO  = 8'h1D;
  localparam logic [7:0]  REG_CLAMP_HI  = 8'h1E;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [3:0]  CLAMP_HI_RST  = 4'h0;
  localparam logic [4:0]  SEL_NONE      = 5'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [2:0]  SYNC_RST      = 3'h3;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ADDR     = 8'h02,
    ST_ACK_ADDR = 8'h04,
    ST_REG      = 8'h08,
    ST_ACK_REG  = 8'h10,
    ST_DATA     = 8'h20,
    ST_ACK_DATA = 8'h40,
    ST_IGNORE   = 8'h80
  } slave_state_t;

  function automatic logic is_out_reg(input logic [7:0] a);
    is_out_reg = (a >= REG_OUT_FIRST) && (a <= REG_OUT_LAST);
  endfunction

  function automatic logic [3:0] out_index(input logic [7:0] a);
    out_index = a[3:0] - REG_OUT_FIRST[3:0];
  endfunction
endpackage

// *** core/pin_sync.sv ***
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import xpoint_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic [SYNC_W-1:0] pin_in,
  output logic      [SYNC_W-1:0] pin_q
);
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] q_nxt;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_bit
      // a change counts once stages two and three agree
      assign q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : pin_q[g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_r  <= SYNC_RST;
      s2_r  <= SYNC_RST;
      s3_r  <= SYNC_RST;
      pin_q <= SYNC_RST;
    end
    else if (clk_en)
    begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_q <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// *** core/video_xpoint_ctrl_regs.sv ***
// serial slave port and control register bank of the video crosspoint
`timescale 1ns/10ps
`default_nettype none
module video_xpoint_ctrl_regs
  import xpoint_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     addr_strap,
  output logic [NUM_OUT-1:0]            video_output_n_en,
  output logic [NUM_OUT-1:0]            video_output_n_hiz,
  output logic [NUM_OUT*GAIN_W-1:0]     amp_gain_code,
  output logic [NUM_OUT*SEL_W-1:0]      video_input_n_sel,
  output logic [NUM_IN-1:0]             input_clamp_sel
);
  // synchronised pins: bit 0 scl, bit 1 sda, bit 2 strap
  logic [SYNC_W-1:0] pins_q;
  logic              scl_q;
  logic              sda_q;
  logic              strap_q;
  logic              scl_d_r;
  logic              sda_d_r;

  pin_sync u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .pin_in ({addr_strap, sda_in, scl_in}),
    .pin_q  (pins_q)
  );

  assign scl_q   = pins_q[0];
  assign sda_q   = pins_q[1];
  assign strap_q = pins_q[2];

  // bus events from the filtered lines
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_q & ~scl_d_r;
  assign scl_fall  = ~scl_q & scl_d_r;
  assign start_det = scl_q & scl_d_r & sda_d_r & ~sda_q;
  assign stop_det  = scl_q & scl_d_r & ~sda_d_r & sda_q;

  slave_state_t      state_r;
  slave_state_t      state_nxt;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [CNT_W-1:0]  bit_cnt_nxt;
  logic [BYTE_W-1:0] shift_r;
  logic [BYTE_W-1:0] shift_nxt;
  logic [BYTE_W-1:0] reg_addr_r;
  logic [BYTE_W-1:0] reg_addr_nxt;
  logic              wr_go;

  logic [BYTE_W-1:0] my_addr;
  logic              addr_hit;
  logic              byte_done;
  logic              in_byte;

  assign my_addr   = strap_q ? ADDR_ALT : ADDR_PRIMARY;
  assign addr_hit  = (shift_r == my_addr);
  assign byte_done = (bit_cnt_r == BITS_PER_BYTE);
  assign in_byte   = (state_r == ST_ADDR) || (state_r == ST_REG) ||
                     (state_r == ST_DATA);

  always_comb
  begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    reg_addr_nxt = reg_addr_r;
    wr_go        = 1'b0;
    if (stop_det)
    begin
      state_nxt = ST_IDLE;
    end
    else if (start_det)
    begin
      state_nxt   = ST_ADDR;
      bit_cnt_nxt = CNT_ZERO;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_REG, ST_DATA:
        begin
          if (scl_rise && !byte_done)
          begin
            shift_nxt   = {shift_r[BYTE_W-2:0], sda_q};
            bit_cnt_nxt = bit_cnt_r + CNT_ONE;
          end
          else if (scl_fall && byte_done)
          begin
            if (state_r == ST_ADDR)
            begin
              // a read request or a foreign address is not acknowledged
              state_nxt = addr_hit ? ST_ACK_ADDR : ST_IGNORE;
            end
            else if (state_r == ST_REG)
            begin
              reg_addr_nxt = shift_r;
              state_nxt    = ST_ACK_REG;
            end
            else
            begin
              wr_go     = 1'b1;
              state_nxt = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA:
        begin
          if (scl_fall)
          begin
            bit_cnt_nxt = CNT_ZERO;
            // a further address/data pair may follow in the same frame
            state_nxt   = (state_r == ST_ACK_REG) ? ST_DATA : ST_REG;
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          state_nxt = state_r;
        end
        default:
        begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= CNT_ZERO;
      shift_r    <= CTRL_RST;
      reg_addr_r <= CTRL_RST;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else if (clk_en)
    begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      reg_addr_r <= reg_addr_nxt;
      scl_d_r    <= scl_q;
      sda_d_r    <= sda_q;
    end
  end

  // acknowledge is the only drive; no data is ever returned
  assign sda_out = 1'b0;
  assign sda_oe  = (state_r == ST_ACK_ADDR) || (state_r == ST_ACK_REG) ||
                   (state_r == ST_ACK_DATA);

  // register bank
  logic [BYTE_W-1:0]     out_ctrl_r [NUM_OUT];
  logic [BYTE_W-1:0]     clamp_lo_r;
  logic [CLAMP_HI_W-1:0] clamp_hi_r;
  logic                  wr_out;
  logic                  wr_clamp_lo;
  logic                  wr_clamp_hi;
  logic [3:0]            out_idx;

  assign out_idx     = out_index(reg_addr_r);
  assign wr_out      = wr_go && is_out_reg(reg_addr_r);
  assign wr_clamp_lo = wr_go && (reg_addr_r == REG_CLAMP_LO);
  assign wr_clamp_hi = wr_go && (reg_addr_r == REG_CLAMP_HI);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        out_ctrl_r[i] <= CTRL_RST;
      end
      clamp_lo_r <= CTRL_RST;
      clamp_hi_r <= CLAMP_HI_RST;
    end
    else if (clk_en)
    begin
      // each output holds its own code, so shared inputs never clash
      if (wr_out)
      begin
        out_ctrl_r[out_idx] <= shift_r;
      end
      if (wr_clamp_lo)
      begin
        clamp_lo_r <= shift_r;
      end
      if (wr_clamp_hi)
      begin
        clamp_hi_r <= shift_r[CLAMP_HI_W-1:0];
      end
    end
  end

  // per-output control to the analog matrix
  logic [NUM_OUT*SEL_W-1:0] sel_eff;
  logic [NUM_OUT-1:0]       hiz_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      assign video_output_n_en[g] = out_ctrl_r[g][EN_BIT];
      assign amp_gain_code[g*GAIN_W +: GAIN_W] =
        out_ctrl_r[g][GAIN_MSB:GAIN_LSB];
      assign hiz_nxt[g] = ~out_ctrl_r[g][EN_BIT];
      assign sel_eff[g*SEL_W +: SEL_W] = out_ctrl_r[g][EN_BIT] ?
        out_ctrl_r[g][SEL_MSB:SEL_LSB] : SEL_NONE;
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      video_output_n_hiz <= '1;
      video_input_n_sel  <= '0;
    end
    else if (clk_en)
    begin
      video_output_n_hiz <= hiz_nxt;
      video_input_n_sel  <= sel_eff;
    end
  end

  assign input_clamp_sel = {clamp_hi_r, clamp_lo_r};

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_addr_acked: assert property (
    clk_en && state_r == ST_ADDR && scl_fall && byte_done && !stop_det &&
    !start_det && shift_r == (strap_q ? ADDR_ALT : ADDR_PRIMARY)
    |=> sda_oe)
    else $error("own address not acknowledged");

  a_foreign_ignored: assert property (
    clk_en && state_r == ST_ADDR && scl_fall && byte_done && !stop_det &&
    !start_det && shift_r != ADDR_PRIMARY && shift_r != ADDR_ALT
    |=> !sda_oe && state_r == ST_IGNORE)
    else $error("foreign address acknowledged");

  a_read_ignored: assert property (
    clk_en && state_r == ST_ADDR && scl_fall && byte_done && !stop_det &&
    !start_det && shift_r[0]
    |=> !sda_oe && state_r == ST_IGNORE)
    else $error("read request acknowledged");

  a_ack_released: assert property (
    clk_en && sda_oe && scl_fall && !stop_det && !start_det
    |=> !sda_oe ##0 (state_r == ST_REG || state_r == ST_DATA))
    else $error("acknowledge not released after its clock");

  a_ack_on_low: assert property (
    $rose(sda_oe) |-> $past(clk_en && scl_fall))
    else $error("acknowledge not started on a clock fall");

  a_reg_acked: assert property (
    clk_en && state_r == ST_REG && scl_fall && byte_done && !stop_det &&
    !start_det
    |=> sda_oe && reg_addr_r == $past(shift_r))
    else $error("register address byte not taken");

  a_data_ack: assert property (
    clk_en && wr_go |=> sda_oe && state_r == ST_ACK_DATA)
    else $error("data byte not acknowledged");

  a_out_reg_write: assert property (
    clk_en && wr_out |=> out_ctrl_r[$past(out_idx)] == $past(shift_r))
    else $error("output register not written");

  a_clamp_write: assert property (
    clk_en && wr_clamp_hi
    |=> input_clamp_sel[NUM_IN-1:BYTE_W] == $past(shift_r[CLAMP_HI_W-1:0]))
    else $error("upper clamp bits not written");

  a_undef_addr: assert property (
    clk_en && wr_go && !is_out_reg(reg_addr_r) &&
    reg_addr_r != REG_CLAMP_LO && reg_addr_r != REG_CLAMP_HI
    |=> $stable(video_output_n_en) && $stable(amp_gain_code) &&
        $stable(input_clamp_sel))
    else $error("undefined address changed control state");

  a_regs_hold: assert property (
    !(clk_en && wr_go)
    |=> $stable(video_output_n_en) && $stable(amp_gain_code) &&
        $stable(input_clamp_sel))
    else $error("control state changed without a write");

  a_enable_freeze: assert property (
    !clk_en |=> $stable(state_r) && $stable(pins_q) && $stable(shift_r))
    else $error("state moved while the clock enable was low");

  a_hiz_follows_en: assert property (
    clk_en ##1 clk_en [*2]
    |-> video_output_n_hiz == ~$past(video_output_n_en))
    else $error("high-impedance control does not follow enable");

  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_chk
      a_off_no_route: assert property (
        clk_en && !video_output_n_en[g]
        |=> video_input_n_sel[g*SEL_W +: SEL_W] == SEL_NONE)
        else $error("powered-down output still routed");

      a_on_routed: assert property (
        clk_en && video_output_n_en[g]
        |=> video_input_n_sel[g*SEL_W +: SEL_W] ==
            $past(out_ctrl_r[g][SEL_MSB:SEL_LSB]))
        else $error("enabled output not routed to its code");
    end
  endgenerate

  a_no_drive_data: assert property (
    in_byte || state_r == ST_IGNORE
    |-> !sda_oe)
    else $error("slave drives the line outside acknowledge");

  a_reset_default: assert property (
    $past(!nrst) |-> video_output_n_en == '0 && amp_gain_code == '0 &&
                     input_clamp_sel == '0 && video_output_n_hiz == '1)
    else $error("registers not at default after reset");

  c_addr_ack: cover property (state_r == ST_ACK_ADDR);
  c_out_write: cover property (clk_en && wr_out);
  c_clamp_write: cover property (clk_en && (wr_clamp_lo || wr_clamp_hi));
  c_ignored: cover property (state_r == ST_IGNORE);
  c_strap_alt: cover property (strap_q && state_r == ST_ACK_ADDR);
endmodule
`default_nettype wire

// *** tb/i2c_master_model.sv ***
// bus master model driving the serial clock and pulling the data line
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model
(
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // also a repeated start: data released while the clock is low
  task automatic start();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask

  // eight bits msb first, then a released ninth bit sampled mid-high
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      tick(4);
      scl = 1'b1;
      tick(8);
      scl = 1'b0;
      tick(4);
    end
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    ack = ~sda;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

// *** tb/video_xpoint_ctrl_regs_test.sv ***
// self-checking bench for the crosspoint control register bank
`timescale 1ns/10ps
`default_nettype none
module video_xpoint_ctrl_regs_test;
  import xpoint_pkg::*;
  logic                      clk, nrst, addr_strap, clk_en;
  logic                      scl, sda, sda_low, sda_out, sda_oe;
  logic [NUM_OUT-1:0]        en_o, hiz_o;
  logic [NUM_OUT*GAIN_W-1:0] gain_o;
  logic [NUM_OUT*SEL_W-1:0]  sel_o;
  logic [NUM_IN-1:0]         clamp_o, exp_clamp;
  logic [7:0]                exp_reg [1:9];
  logic [7:0]                bad [5] = '{8'h00, 8'h0A, 8'h1C, 8'h1F, 8'hFF};
  int                        errors, total_checks;

  // open-drain wire with pull-up
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  video_xpoint_ctrl_regs uut (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .video_output_n_en(en_o),
    .video_output_n_hiz(hiz_o), .amp_gain_code(gain_o),
    .video_input_n_sel(sel_o), .input_clamp_sel(clamp_o));

  i2c_master_model master (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [63:0] expect_of(input int f);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < NUM_OUT; i++)
    begin
      case (f)
        0: v[i] = exp_reg[i+1][7];
        1: v[i] = ~exp_reg[i+1][7];
        2: v[2*i +: 2] = exp_reg[i+1][6:5];
        default: v[5*i +: 5] = exp_reg[i+1][7] ? exp_reg[i+1][4:0] : 5'h00;
      endcase
    end
    return (f == 4) ? {52'h0, exp_clamp} : v;
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    check({55'h0, en_o}, expect_of(0));
    check({55'h0, hiz_o}, expect_of(1));
    check({46'h0, gain_o}, expect_of(2));
    check({19'h0, sel_o}, expect_of(3));
    check({52'h0, clamp_o}, expect_of(4));
  endtask

  task automatic sb(input logic [7:0] b, input logic e);
    logic ack;
    master.send(b, ack);
    check({63'h0, ack}, {63'h0, e});
  endtask

  task automatic pair(input logic [7:0] a, input logic [7:0] d);
    sb(a, 1'b1);
    sb(d, 1'b1);
    if (a >= REG_OUT_FIRST && a <= REG_OUT_LAST)
      exp_reg[a[3:0]] = d;
    else if (a == REG_CLAMP_LO)
      exp_clamp[7:0] = d;
    else if (a == REG_CLAMP_HI)
      exp_clamp[11:8] = d[3:0];
  endtask

  task automatic finish_frame();
    master.stop();
    master.tick(4);
    check_all();
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    logic [7:0] a, d;
    int         n;
    errors = 0;
    total_checks = 0;
    nrst = 1'b0;
    addr_strap = 1'b0;
    clk_en = 1'b1;
    exp_clamp = '0;
    for (int i = 1; i <= 9; i++)
      exp_reg[i] = 8'h00;
    void'($urandom(32'h3379d088));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check_all();
    $display("test reset done");
    // every output on input twelve, all gain codes, back to back
    master.start();
    sb(ADDR_PRIMARY, 1'b1);
    for (int i = 1; i <= 9; i++)
      pair(i[7:0], {1'b1, 2'(i % 4), 5'h0C});
    finish_frame();
    $display("test fanout done");
    // a frozen block must neither answer nor change its outputs
    clk_en = 1'b0;
    master.start();
    sb(ADDR_PRIMARY, 1'b0);
    finish_frame();
    clk_en = 1'b1;
    $display("test freeze done");
    for (int k = 0; k < 40; k++)
    begin
      master.start();
      sb(ADDR_PRIMARY, 1'b1);
      n = $urandom_range(2, 1);
      repeat (n)
      begin
        if ($urandom_range(4, 0) == 0)
          a = 8'(32'h1D + $urandom_range(1, 0));
        else
          a = 8'($urandom_range(9, 1));
        d = 8'($urandom);
        if (a <= REG_OUT_LAST)
          d[4:0] = 5'($urandom_range(12, 0));
        pair(a, d);
      end
      finish_frame();
    end
    $display("test random done");
    master.start();
    sb(ADDR_ALT, 1'b0);
    sb(8'h01, 1'b0);
    sb(8'hFF, 1'b0);
    master.start();
    sb(8'h07, 1'b0);
    sb(8'h02, 1'b0);
    finish_frame();
    $display("test refused done");
    master.start();
    sb(ADDR_PRIMARY, 1'b1);
    foreach (bad[j])
      pair(bad[j], 8'hFF);
    sb(8'h02, 1'b1);
    finish_frame();
    $display("test unmapped done");
    addr_strap = 1'b1;
    master.tick(8);
    master.start();
    sb(ADDR_PRIMARY, 1'b0);
    master.start();
    sb(ADDR_ALT, 1'b1);
    pair(REG_CLAMP_HI, 8'hF5);
    pair(8'h05, 8'h27);
    finish_frame();
    $display("test strap done");
    final_report();
  end
endmodule
`default_nettype wire
